// ### rtl/cbc_defines.svh
`ifndef CBC_DEFINES_SVH
`define CBC_DEFINES_SVH

// widths
`define CBC_WORD_W        16
`define CBC_PC_W          21
`define CBC_STATUS_W      5

// upper byte of each conditional branch word
`define CBC_OP_CARRY_CLR  8'he3
`define CBC_OP_NEG_CLR    8'he7
`define CBC_OP_OVF_CLR    8'he5
`define CBC_OP_ZERO_CLR   8'he1

// bit positions of the flags in the status word
`define CBC_FLAG_CARRY    0
`define CBC_FLAG_ZERO     2
`define CBC_FLAG_OVF      3
`define CBC_FLAG_NEG      4

// instruction cycles of a branch
`define CBC_CYC_NOT_TAKEN 1
`define CBC_CYC_TAKEN     2

`endif

// ### rtl/cbc_pkg.sv
package cbc_pkg;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_CARRY_CLR,
        KIND_NEG_CLR,
        KIND_OVF_CLR,
        KIND_ZERO_CLR
    } cbc_kind_t;

    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } cbc_phase_t;

    typedef enum logic {
        CYC_EXEC,
        CYC_FLUSH
    } cbc_cyc_t;

endpackage : cbc_pkg

// ### rtl/cbc_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbc_defines.svh"

interface cbc_dec_if;
    logic [`CBC_WORD_W-1:0] word;
    cbc_pkg::cbc_kind_t     kind;

    modport core (output word, input kind);
    modport dec  (input word, output kind);
endinterface : cbc_dec_if

`default_nettype wire

// ### rtl/cbc_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbc_defines.svh"

module cbc_decode (
    cbc_dec_if.dec dec
);

    // classifies the upper byte; the low byte is the offset literal
    always_comb begin
        unique case (dec.word[15:8])
            `CBC_OP_CARRY_CLR: dec.kind = cbc_pkg::KIND_CARRY_CLR;
            `CBC_OP_NEG_CLR:   dec.kind = cbc_pkg::KIND_NEG_CLR;
            `CBC_OP_OVF_CLR:   dec.kind = cbc_pkg::KIND_OVF_CLR;
            `CBC_OP_ZERO_CLR:  dec.kind = cbc_pkg::KIND_ZERO_CLR;
            default:           dec.kind = cbc_pkg::KIND_NONE;
        endcase
    end

endmodule : cbc_decode

`default_nettype wire

// ### rtl/cbc_branch.sv
// Function
// - word e3nn is branch on carry clear, taken only when carry is 0.
// - word e7nn is branch on negative clear, taken only when negative is 0.
// - word e5nn is branch on overflow clear, taken only when overflow is 0.
// - word e1nn is branch on zero clear, taken only when zero is 0.
// - a taken branch loads the pc with pc plus two plus twice the signed offset.
// - the doubled offset is added to the pc already advanced past the branch.
// - a branch takes one instruction cycle when not taken, two when taken.
`timescale 1ns/1ps
`default_nettype none
`include "cbc_defines.svh"

module cbc_branch (
    // clock and reset
    input  wire logic                     clk_sys_in,
    input  wire logic                     sys_rst_in,
    // fetch side
    input  wire logic [`CBC_WORD_W-1:0]   instr_in,
    input  wire logic                     instr_valid_in,
    input  wire logic [`CBC_PC_W-1:0]     pc_in,
    // status register
    input  wire logic [`CBC_STATUS_W-1:0] status_in,
    output logic                          status_we_out,
    // program counter
    output logic                          pc_load_out,
    output logic [`CBC_PC_W-1:0]          pc_value_out,
    // sequencing
    output logic [1:0]                    phase_out,
    output logic                          claim_out,
    output logic                          taken_out,
    output logic                          flush_out,
    output logic                          done_out
);

    cbc_dec_if dec_bus ();

    cbc_pkg::cbc_phase_t  phase;
    cbc_pkg::cbc_cyc_t    cyc;
    cbc_pkg::cbc_kind_t   kind_q;
    logic                 active;
    logic [`CBC_WORD_W-1:0] word_q;
    logic [7:0]           offset_q;
    logic                 next_taken;
    logic [`CBC_PC_W-1:0] next_target;
    logic                 exec_q1;
    logic                 exec_q3;
    logic                 flush_q3;

    // true when the flag tested by this kind is clear
    function automatic logic cond_clear(
        input cbc_pkg::cbc_kind_t      kind,
        input logic [`CBC_STATUS_W-1:0] st
    );
        logic r;
        r = 1'b0;
        unique case (kind)
            cbc_pkg::KIND_CARRY_CLR: r = ~st[`CBC_FLAG_CARRY];
            cbc_pkg::KIND_NEG_CLR:   r = ~st[`CBC_FLAG_NEG];
            cbc_pkg::KIND_OVF_CLR:   r = ~st[`CBC_FLAG_OVF];
            cbc_pkg::KIND_ZERO_CLR:  r = ~st[`CBC_FLAG_ZERO];
            cbc_pkg::KIND_NONE:      r = 1'b0;
        endcase
        return r;
    endfunction : cond_clear

    // advanced pc plus the sign-extended offset doubled
    function automatic logic [`CBC_PC_W-1:0] branch_target(
        input logic [`CBC_PC_W-1:0] pc_adv,
        input logic [7:0]           n
    );
        logic [`CBC_PC_W-1:0] disp;
        disp = {{(`CBC_PC_W-9){n[7]}}, n, 1'b0};
        return pc_adv + disp;
    endfunction : branch_target

    // true in the given quarter of the given kind of instruction cycle
    function automatic logic in_quarter(
        input cbc_pkg::cbc_phase_t ph,
        input cbc_pkg::cbc_cyc_t   cy,
        input cbc_pkg::cbc_phase_t q,
        input cbc_pkg::cbc_cyc_t   c
    );
        return ph == q && cy == c;
    endfunction : in_quarter

    assign dec_bus.word = instr_in;

    // sequencer strobes shared by the per-quarter registers
    assign exec_q1  = in_quarter(phase, cyc, cbc_pkg::PH_Q1,
                                 cbc_pkg::CYC_EXEC);
    assign exec_q3  = in_quarter(phase, cyc, cbc_pkg::PH_Q3,
                                 cbc_pkg::CYC_EXEC);
    assign flush_q3 = in_quarter(phase, cyc, cbc_pkg::PH_Q3,
                                 cbc_pkg::CYC_FLUSH);

    cbc_decode u_decode (
        .dec (dec_bus.dec)
    );

    // one instruction cycle is four clocks, q1 to q4
    //   edge ending q1: word latched and classified
    //   edge ending q2: offset literal latched
    //   edge ending q3: flag tested, target and strobes registered
    //   edge ending q4: cycle state advances
    // pc_load_out and done_out therefore stand during q4
    // a taken branch adds a flush cycle whose prefetched word is dropped;
    // fetch keeps offering words then, and none of them is claimed

    // quarter-phase sequencer, free running
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase <= cbc_pkg::PH_Q1;
        end else begin
            unique case (phase)
                cbc_pkg::PH_Q1: phase <= cbc_pkg::PH_Q2;
                cbc_pkg::PH_Q2: phase <= cbc_pkg::PH_Q3;
                cbc_pkg::PH_Q3: phase <= cbc_pkg::PH_Q4;
                cbc_pkg::PH_Q4: phase <= cbc_pkg::PH_Q1;
            endcase
        end
    end

    // instruction cycle: a taken branch adds one flush cycle
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cyc <= cbc_pkg::CYC_EXEC;
        end else if (phase == cbc_pkg::PH_Q4) begin
            unique case (cyc)
                cbc_pkg::CYC_EXEC: begin
                    if (active && taken_out) begin
                        cyc <= cbc_pkg::CYC_FLUSH;
                    end
                end
                cbc_pkg::CYC_FLUSH: cyc <= cbc_pkg::CYC_EXEC;
            endcase
        end
    end

    // q1: decode and claim the word offered by fetch
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            active <= 1'b0;
            kind_q <= cbc_pkg::KIND_NONE;
            word_q <= '0;
        end else if (phase == cbc_pkg::PH_Q1) begin
            if (exec_q1 && instr_valid_in) begin
                active <= dec_bus.kind != cbc_pkg::KIND_NONE;
                kind_q <= dec_bus.kind;
                word_q <= instr_in;
            end else begin
                // the flush cycle discards the prefetched word
                active <= 1'b0;
                kind_q <= cbc_pkg::KIND_NONE;
            end
        end
    end

    // q2: read the offset literal
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            offset_q <= 8'h00;
        end else if (phase == cbc_pkg::PH_Q2) begin
            offset_q <= word_q[7:0];
        end
    end

    // q3: test the flag and form the target
    always_comb begin
        next_taken  = active && cond_clear(kind_q, status_in);
        next_target = branch_target(pc_in, offset_q);
    end

    // condition result, held through the flush cycle
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            taken_out <= 1'b0;
        end else if (exec_q3) begin
            taken_out <= next_taken;
        end
    end

    // target is formed on every execute q3; only pc_load_out makes it count
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pc_value_out <= '0;
        end else if (exec_q3) begin
            pc_value_out <= next_target;
        end
    end

    // q4: pc write strobe only on a taken branch
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pc_load_out <= 1'b0;
        end else begin
            pc_load_out <= exec_q3 && next_taken;
        end
    end

    // completion strobe in q4 of the last cycle of the branch
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= (exec_q3 && active && !next_taken)
                     || flush_q3;
        end
    end

    assign phase_out     = phase;
    // high from q2 of an execute cycle up to the next q1 edge
    assign claim_out     = active;
    // high for the whole cycle after a taken branch
    assign flush_out     = cyc == cbc_pkg::CYC_FLUSH;
    // branches never touch the flags
    assign status_we_out = 1'b0;

endmodule : cbc_branch

`default_nettype wire

// ### bench/cbc_core_mdl.sv
`timescale 1ns/1ps
`default_nettype none
module cbc_core_mdl (
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire logic        load_in,
    input  wire logic [20:0] value_in,
    output logic      [20:0] pc_out
);
    // program counter of the core, written only by the load pulse
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) pc_out <= 21'h000000;
        else if (load_in) pc_out <= value_in;
    end
endmodule : cbc_core_mdl
`default_nettype wire

// ### bench/cbc_branch_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbc_defines.svh"
module cbc_branch_sva (
    input wire logic        clk_sys_in,
    input wire logic        sys_rst_in,
    input wire logic [15:0] instr_in,
    input wire logic        instr_valid_in,
    input wire logic [20:0] pc_in,
    input wire logic [4:0]  status_in,
    input wire logic        status_we_out,
    input wire logic        pc_load_out,
    input wire logic [20:0] pc_value_out,
    input wire logic [1:0]  phase_out,
    input wire logic        claim_out,
    input wire logic        taken_out,
    input wire logic        flush_out,
    input wire logic        done_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    logic [15:0] w;
    // word seen at the close of q1
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) w <= 16'h0000;
        else if (phase_out == 2'h0) w <= instr_in;
    end
    function automatic logic go(input logic [15:0] x, input logic [4:0] s);
        case (x[15:8])
            `CBC_OP_CARRY_CLR: go = !s[`CBC_FLAG_CARRY];
            `CBC_OP_NEG_CLR:   go = !s[`CBC_FLAG_NEG];
            `CBC_OP_OVF_CLR:   go = !s[`CBC_FLAG_OVF];
            `CBC_OP_ZERO_CLR:  go = !s[`CBC_FLAG_ZERO];
            default:           go = 1'b0;
        endcase
    endfunction : go
    sequence s_take;
        phase_out == 2'h0 && !flush_out && instr_valid_in &&
        (instr_in[15:8] inside {8'he3, 8'he7, 8'he5, 8'he1});
    endsequence
    sequence s_q4;
        claim_out && phase_out == 2'h3;
    endsequence
    property p_claim; s_take |=> claim_out; endproperty
    a_claim: assert property (p_claim) else $error("word not claimed");
    property p_cond; s_q4 |-> taken_out == go(w, $past(status_in)); endproperty
    a_cond: assert property (p_cond) else $error("bad condition");
    property p_target;
        pc_load_out |-> pc_value_out == $past(pc_in) + {{12{w[7]}}, w[7:0], 1'b0};
    endproperty
    a_target: assert property (p_target) else $error("bad target");
    property p_load; s_q4 |-> pc_load_out == taken_out && done_out != taken_out; endproperty
    a_load: assert property (p_load) else $error("bad q4 result");
    property p_q4; pc_load_out |-> claim_out && phase_out == 2'h3; endproperty
    a_q4: assert property (p_q4) else $error("pc written off q4");
    property p_flush; pc_load_out |=> flush_out [*4] ##1 !flush_out; endproperty
    a_flush: assert property (p_flush) else $error("bad flush");
    property p_done; pc_load_out |-> ##4 done_out; endproperty
    a_done: assert property (p_done) else $error("late done");
    property p_phase;
        !$past(sys_rst_in) |-> phase_out == 2'($past(phase_out) + 2'h1);
    endproperty
    a_phase: assert property (p_phase) else $error("phase skipped");
    property p_status; !status_we_out; endproperty
    a_status: assert property (p_status) else $error("flags written");
endmodule : cbc_branch_sva
bind cbc_branch cbc_branch_sva u_sva (.clk_sys_in, .sys_rst_in, .instr_in,
    .instr_valid_in, .pc_in, .status_in, .status_we_out, .pc_load_out,
    .pc_value_out, .phase_out, .claim_out, .taken_out, .flush_out, .done_out);
`default_nettype wire

// ### bench/cond_branch_on_clear_flag_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cond_branch_on_clear_flag_bench;
    logic        clk_sys_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        instr_valid_in = 1'b0;
    logic [15:0] instr_in = 16'h0000;
    logic [20:0] pc_in = 21'h000000;
    logic [4:0]  status_in = 5'h00;
    logic        status_we_out, pc_load_out, claim_out, taken_out;
    logic        flush_out, done_out;
    logic [20:0] pc_value_out, mdl_pc;
    logic [1:0]  phase_out;
    logic [7:0]  ops [6] = '{8'he3, 8'he7, 8'he5, 8'he1, 8'he6, 8'h00};
    int          error_cnt = 0;
    int          check_count = 0;
    int          cyc = 0;
    cbc_branch u_dut (.clk_sys_in, .sys_rst_in, .instr_in, .instr_valid_in,
        .pc_in, .status_in, .status_we_out, .pc_load_out, .pc_value_out,
        .phase_out, .claim_out, .taken_out, .flush_out, .done_out);
    cbc_core_mdl u_mdl (.clk_sys_in, .sys_rst_in, .load_in(pc_load_out),
        .value_in(pc_value_out), .pc_out(mdl_pc));
    initial begin
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    task check(input logic [20:0] seen, input logic [20:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task give_verdict;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            give_verdict;
        end
    end
    // {is branch, taken}
    function automatic logic [1:0] want(input logic [15:0] x,
                                        input logic [4:0] s);
        case (x[15:8])
            8'he3:   return {1'b1, !s[0]};
            8'he7:   return {1'b1, !s[4]};
            8'he5:   return {1'b1, !s[3]};
            8'he1:   return {1'b1, !s[2]};
            default: return 2'b00;
        endcase
    endfunction : want
    function automatic logic [20:0] tgt(input logic [20:0] p,
                                        input logic [7:0] n);
        return p + {{12{n[7]}}, n, 1'b0};
    endfunction : tgt
    // the word stays on the bus through the flush, where it must be ignored
    task run(input logic [15:0] x, input logic [4:0] s, input logic [20:0] p,
             input logic v);
        logic [1:0] e;
        e = v ? want(x, s) : 2'b00;
        do @(posedge clk_sys_in); while (phase_out !== 2'h3);
        instr_in <= x;
        instr_valid_in <= v;
        status_in <= s;
        pc_in <= p;
        repeat (3) @(posedge clk_sys_in);
        #1;
        check(21'(phase_out), 21'h3);
        check(21'(claim_out), 21'(e[1]));
        check(21'(pc_load_out), 21'(e[0]));
        check(21'(taken_out), 21'(e[0]));
        check(21'(done_out), 21'(e[1] & !e[0]));
        check(21'(flush_out), 21'h0);
        check(21'(status_we_out), 21'h0);
        if (e[0]) begin
            check(pc_value_out, tgt(p, x[7:0]));
            repeat (4) @(posedge clk_sys_in);
            #1;
            check(21'(done_out), 21'h1);
            check(21'(flush_out), 21'h1);
            check(21'(pc_load_out), 21'h0);
            check(21'(claim_out), 21'h0);
            check(mdl_pc, tgt(p, x[7:0]));
        end
    endtask : run
    initial begin
        void'($urandom(32'h3930));
        repeat (4) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            run({ops[i], 8'h80}, 5'h00, 21'h000000, 1'b1);
            run({ops[i], 8'h7f}, 5'h1f, 21'h001000, 1'b1);
            run({ops[i], 8'h7f}, 5'h00, 21'h1fff00, 1'b1);
            run({ops[i], 8'h01}, 5'h00, 21'h000200, 1'b0);
        end
        run(16'he605, 5'h00, 21'h000100, 1'b1);
        repeat (150) begin
            run({ops[$urandom % 6], 8'($urandom)}, 5'($urandom), 21'($urandom),
                ($urandom % 8) != 0);
        end
        give_verdict;
    end
endmodule : cond_branch_on_clear_flag_bench
`default_nettype wire
